// ---- src/i2ci_top.sv ----
// interrupt status and clear registers of the two-wire controller
`timescale 1ns/1ps
`include "i2ci_map.svh"

module i2ci_top (
  input  wire  logic              MCLK,
  input  wire  logic              NRST,
  input  wire  i2ci_pkg::i2ci_addr_t S_AXI_AWADDR,
  input  wire  logic              S_AXI_AWVALID,
  output logic                    S_AXI_AWREADY,
  input  wire  i2ci_pkg::i2ci_word_t S_AXI_WDATA,
  input  wire  i2ci_pkg::i2ci_strb_t S_AXI_WSTRB,
  input  wire  logic              S_AXI_WVALID,
  output logic                    S_AXI_WREADY,
  output i2ci_pkg::i2ci_resp_t    S_AXI_BRESP,
  output logic                    S_AXI_BVALID,
  input  wire  logic              S_AXI_BREADY,
  input  wire  i2ci_pkg::i2ci_addr_t S_AXI_ARADDR,
  input  wire  logic              S_AXI_ARVALID,
  output logic                    S_AXI_ARREADY,
  output i2ci_pkg::i2ci_word_t    S_AXI_RDATA,
  output i2ci_pkg::i2ci_resp_t    S_AXI_RRESP,
  output logic                    S_AXI_RVALID,
  input  wire  logic              S_AXI_RREADY,
  input  wire  i2ci_pkg::i2ci_cnt_t TX_COUNT,
  input  wire  i2ci_pkg::i2ci_cnt_t RX_COUNT,
  input  wire  logic              TX_OVERRUN_EVT,
  input  wire  logic              SLV_RD_REQ_EVT,
  input  wire  logic              SLV_RD_ACTIVE,
  input  wire  logic              SLV_WR_REQ_EVT,
  input  wire  logic              MST_DONE_EVT,
  input  wire  logic              MST_DONE_NOSTOP_EVT,
  input  wire  logic              SLV_DONE_EVT,
  input  wire  logic              ARB_LOST_EVT,
  input  wire  logic              XFER_ACTIVE,
  input  wire  logic              SCL_IN,
  input  wire  logic              SDA_IN,
  output logic                    SCL_OUT,
  output logic                    SCL_OE,
  output logic                    IRQ
);
  import i2ci_pkg::*;

  // ==========================================
  // helpers

  // byte-lane merge of a bus write into a stored word
  function automatic i2ci_word_t lane_merge(
    input i2ci_word_t old_v,
    input i2ci_word_t new_v,
    input i2ci_strb_t strb
  );
    i2ci_word_t r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================
  // bus write channel

  logic       bvalid_q;
  logic       bvalid_d;
  i2ci_resp_t bresp_q;
  i2ci_resp_t bresp_d;

  wire        wr_go;
  wire        wr_hit;
  wire        wr_clr;
  wire        wr_mask;
  wire        wr_txthr;
  wire        wr_rxthr;
  i2ci_word_t wd_m;

  // both channels taken on the same edge; no buffering needed
  assign wr_go    = S_AXI_AWVALID && S_AXI_WVALID && !bvalid_q;
  assign wr_clr   = wr_go && (S_AXI_AWADDR == `I2CI_CLR_OFS);
  assign wr_mask  = wr_go && (S_AXI_AWADDR == `I2CI_MASK_OFS);
  assign wr_txthr = wr_go && (S_AXI_AWADDR == `I2CI_TXTHR_OFS);
  assign wr_rxthr = wr_go && (S_AXI_AWADDR == `I2CI_RXTHR_OFS);
  assign wr_hit   = wr_clr || wr_mask || wr_txthr || wr_rxthr ||
                    (S_AXI_AWADDR == `I2CI_RAW_OFS) ||
                    (S_AXI_AWADDR == `I2CI_STAT_OFS);
  assign wd_m     = lane_merge(`I2CI_RST_W, S_AXI_WDATA, S_AXI_WSTRB);

  assign S_AXI_AWREADY = wr_go;
  assign S_AXI_WREADY  = wr_go;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;

  assign bvalid_d = wr_go || (bvalid_q && !S_AXI_BREADY);
  assign bresp_d  = wr_go ? (wr_hit ? I2CI_OKAY : I2CI_SLVERR) : bresp_q;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      bvalid_q <= 1'b0;
      bresp_q  <= I2CI_OKAY;
    end else begin
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
    end
  end

  // ==========================================
  // software-written registers

  i2ci_word_t mask_q;
  i2ci_word_t mask_d;
  logic [`I2CI_THR_W-1:0] txthr_q;
  logic [`I2CI_THR_W-1:0] txthr_d;
  logic [`I2CI_THR_W-1:0] rxthr_q;
  logic [`I2CI_THR_W-1:0] rxthr_d;
  i2ci_word_t tx_merge;
  i2ci_word_t rx_merge;

  assign mask_d   = wr_mask ?
                    (lane_merge(mask_q, S_AXI_WDATA, S_AXI_WSTRB) & `I2CI_VALID_M) : mask_q;
  assign tx_merge = lane_merge({27'h0, txthr_q}, S_AXI_WDATA, S_AXI_WSTRB);
  assign rx_merge = lane_merge({27'h0, rxthr_q}, S_AXI_WDATA, S_AXI_WSTRB);
  assign txthr_d  = wr_txthr ? tx_merge[`I2CI_THR_W-1:0] : txthr_q;
  assign rxthr_d  = wr_rxthr ? rx_merge[`I2CI_THR_W-1:0] : rxthr_q;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      mask_q  <= `I2CI_RST_W;
      txthr_q <= `I2CI_THR_RST;
      rxthr_q <= `I2CI_THR_RST;
    end else begin
      mask_q  <= mask_d;
      txthr_q <= txthr_d;
      rxthr_q <= rxthr_d;
    end
  end

  // ==========================================
  // clear strobes, one cycle, only on a write of one

  i2ci_word_t clr;
  assign clr = wr_clr ? (wd_m & `I2CI_STICKY_M) : `I2CI_RST_W;

  // ==========================================
  // bus line sampling and start/stop detection

  logic scl_s1_q;
  logic scl_s2_q;
  logic sda_s1_q;
  logic sda_s2_q;
  logic sda_s3_q;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= SCL_IN;
      scl_s2_q <= scl_s1_q;
      sda_s1_q <= SDA_IN;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  wire start_det;
  wire stop_det;
  wire bus_error_raw_evt;

  assign start_det = scl_s2_q && sda_s3_q && !sda_s2_q;
  assign stop_det  = scl_s2_q && !sda_s3_q && sda_s2_q;
  // engine drops the active flag before its own stop, so any seen inside is stray
  assign bus_error_raw_evt  = XFER_ACTIVE && (start_det || stop_det);

  // ==========================================
  // sticky events

  i2ci_word_t sticky_q;
  i2ci_word_t sticky_d;
  i2ci_word_t set_v;
  logic       srr_def_q;
  logic       srr_def_d;
  logic       swr_def_q;
  logic       swr_def_d;
  logic       sre_cond_q;
  wire        tx_empty;
  wire        sre_cond;
  wire        nostop;
  wire        rel_def;

  assign tx_empty = (TX_COUNT == 5'h00);
  assign sre_cond = tx_empty && SLV_RD_ACTIVE;
  assign nostop   = sticky_q[`I2CI_B_MDNS];
  // deferred slave requests are released once no-stop is gone
  assign rel_def  = !nostop;

  assign srr_def_d = nostop ? (srr_def_q || SLV_RD_REQ_EVT) : 1'b0;
  assign swr_def_d = nostop ? (swr_def_q || SLV_WR_REQ_EVT) : 1'b0;

  always_comb begin
    set_v = `I2CI_RST_W;
    set_v[`I2CI_B_TXOV] = TX_OVERRUN_EVT;
    set_v[`I2CI_B_SRR]  = rel_def && (SLV_RD_REQ_EVT || srr_def_q);
    set_v[`I2CI_B_SRE]  = sre_cond && !sre_cond_q;
    set_v[`I2CI_B_SWR]  = rel_def && (SLV_WR_REQ_EVT || swr_def_q);
    set_v[`I2CI_B_MD]   = MST_DONE_EVT;
    set_v[`I2CI_B_SD]   = SLV_DONE_EVT;
    set_v[`I2CI_B_AL]   = ARB_LOST_EVT;
    set_v[`I2CI_B_BE]   = bus_error_raw_evt;
    set_v[`I2CI_B_MDNS] = MST_DONE_NOSTOP_EVT;
  end

  // set wins over a clear in the same cycle
  always_comb begin
    sticky_d = ((sticky_q & ~clr) | set_v) & `I2CI_STICKY_M;
    if (!tx_empty) begin
      sticky_d[`I2CI_B_SRE] = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      sticky_q   <= `I2CI_RST_W;
      srr_def_q  <= 1'b0;
      swr_def_q  <= 1'b0;
      sre_cond_q <= 1'b0;
    end else begin
      sticky_q   <= sticky_d;
      srr_def_q  <= srr_def_d;
      swr_def_q  <= swr_def_d;
      sre_cond_q <= sre_cond;
    end
  end

  // ==========================================
  // raw and masked status

  i2ci_word_t raw;
  i2ci_word_t masked;

  always_comb begin
    raw = sticky_q;
    raw[`I2CI_B_TXE]  = tx_empty;
    raw[`I2CI_B_TXNE] = (TX_COUNT <= txthr_q);
    raw[`I2CI_B_TXF]  = (TX_COUNT == `I2CI_DEPTH);
    raw[`I2CI_B_RXE]  = (RX_COUNT == 5'h00);
    raw[`I2CI_B_RXNF] = (RX_COUNT >= rxthr_q);
    raw[`I2CI_B_RXF]  = (RX_COUNT == `I2CI_DEPTH);
  end

  assign masked  = raw & mask_q & `I2CI_VALID_M;
  assign IRQ     = |masked;
  // clock held low by the open-drain pad while no-stop is pending
  assign SCL_OUT = 1'b0;
  assign SCL_OE  = nostop;

  // ==========================================
  // bus read channel

  logic       rvalid_q;
  logic       rvalid_d;
  i2ci_word_t rdata_q;
  i2ci_word_t rdata_d;
  i2ci_resp_t rresp_q;
  i2ci_resp_t rresp_d;
  wire        rd_go;
  wire        rd_hit;
  i2ci_word_t rd_mux;

  assign rd_go  = S_AXI_ARVALID && !rvalid_q;
  assign rd_hit = (S_AXI_ARADDR == `I2CI_STAT_OFS) || (S_AXI_ARADDR == `I2CI_RAW_OFS) ||
                  (S_AXI_ARADDR == `I2CI_MASK_OFS) || (S_AXI_ARADDR == `I2CI_CLR_OFS) ||
                  (S_AXI_ARADDR == `I2CI_TXTHR_OFS) || (S_AXI_ARADDR == `I2CI_RXTHR_OFS);
  // clear register is write-action only and always reads zero
  assign rd_mux = (S_AXI_ARADDR == `I2CI_STAT_OFS)  ? masked :
                  (S_AXI_ARADDR == `I2CI_RAW_OFS)   ? (raw & `I2CI_VALID_M) :
                  (S_AXI_ARADDR == `I2CI_MASK_OFS)  ? mask_q :
                  (S_AXI_ARADDR == `I2CI_TXTHR_OFS) ? {27'h0, txthr_q} :
                  (S_AXI_ARADDR == `I2CI_RXTHR_OFS) ? {27'h0, rxthr_q} :
                  `I2CI_RST_W;

  assign S_AXI_ARREADY = rd_go;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;

  assign rvalid_d = rd_go || (rvalid_q && !S_AXI_RREADY);
  assign rdata_d  = rd_go ? rd_mux : rdata_q;
  assign rresp_d  = rd_go ? (rd_hit ? I2CI_OKAY : I2CI_SLVERR) : rresp_q;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rvalid_q <= 1'b0;
      rdata_q  <= `I2CI_RST_W;
      rresp_q  <= I2CI_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // ==========================================
  // checks

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!NRST);

  sequence s_clr_ov;
    wr_clr && wd_m[`I2CI_B_TXOV];
  endsequence

  sequence s_nostop_wr_req;
    nostop && SLV_WR_REQ_EVT && !sticky_q[`I2CI_B_SWR];
  endsequence

  property p_irq_or;
    IRQ == (|(raw & mask_q));
  endproperty
  a_irq_or: assert property (p_irq_or) else $error("irq not OR of masked");

  property p_tx_empty;
    masked[`I2CI_B_TXE] == ((TX_COUNT == 5'h00) && mask_q[`I2CI_B_TXE]);
  endproperty
  a_tx_empty: assert property (p_tx_empty) else $error("tx empty bit wrong");

  property p_tx_thr;
    raw[`I2CI_B_TXNE] == !(TX_COUNT > txthr_q);
  endproperty
  a_tx_thr: assert property (p_tx_thr) else $error("tx threshold bit wrong");

  property p_rx_thr;
    raw[`I2CI_B_RXNF] == !(RX_COUNT < rxthr_q);
  endproperty
  a_rx_thr: assert property (p_rx_thr) else $error("rx threshold bit wrong");

  property p_ov_set;
    TX_OVERRUN_EVT |=> sticky_q[`I2CI_B_TXOV];
  endproperty
  a_ov_set: assert property (p_ov_set) else $error("overrun not latched");

  property p_ov_clr;
    s_clr_ov and !TX_OVERRUN_EVT |=> !sticky_q[`I2CI_B_TXOV];
  endproperty
  a_ov_clr: assert property (p_ov_clr) else $error("overrun not cleared");

  property p_ov_hold;
    sticky_q[`I2CI_B_TXOV] && !(wr_clr && wd_m[`I2CI_B_TXOV]) |=> sticky_q[`I2CI_B_TXOV];
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("overrun lost");

  property p_bus_error_raw;
    XFER_ACTIVE && start_det |=> sticky_q[`I2CI_B_BE];
  endproperty
  a_bus_error_raw: assert property (p_bus_error_raw) else $error("bus error missed");

  property p_hold_scl;
    MST_DONE_NOSTOP_EVT |=> SCL_OE && !SCL_OUT;
  endproperty
  a_hold_scl: assert property (p_hold_scl) else $error("clock not held");

  property p_defer;
    s_nostop_wr_req |=> !sticky_q[`I2CI_B_SWR] && swr_def_q;
  endproperty
  a_defer: assert property (p_defer) else $error("slave request not deferred");

  property p_bus_clr;
    wr_clr && wd_m[`I2CI_B_BE] && !bus_error_raw_evt |=> !sticky_q[`I2CI_B_BE];
  endproperty
  a_bus_clr: assert property (p_bus_clr) else $error("bus error not cleared");

  property p_resv;
    S_AXI_RVALID |-> (S_AXI_RDATA & ~`I2CI_VALID_M) == `I2CI_RST_W;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits nonzero");

endmodule

// ---- src/i2ci_map.svh ----
// register map, field positions, reset values and FIFO depth
//
// Summary of operation
// - bit 0 set when transmit FIFO empty and enabled
// - bit 1 set when transmit count is at or below transmit threshold
// - bit 2 set while transmit FIFO full and enabled
// - bit 3 latches a transmit overrun until software clears it
// - bit 4 set when receive FIFO holds no entries
// - bit 5 set when receive count is at or above receive threshold
// - bit 6 set while receive FIFO full
// - bit 16 set while a slave read request is pending
// - bit 17 set when transmit FIFO runs empty during slave read
// - bit 18 set while a slave write request is pending
// - bit 19 set when master transaction done, until acknowledged
// - bit 20 set when slave transaction done, until acknowledged
// - bit 24 set after master arbitration loss until cleared
// - bit 25 set after bus error until cleared
// - bit 28 set when master transaction ends without stop
// - writing one to clear bit 3 clears overrun; zero leaves it
// - writing one to clear bits 16-28 clears matching event; zero does nothing
// - bus error raised on start or stop inside a transaction
// - while no-stop done pending, hold clock low and defer slave requests
`ifndef I2CI_MAP_SVH
`define I2CI_MAP_SVH

// ==========================================
// offsets
`define I2CI_TXTHR_OFS 8'h20
`define I2CI_RXTHR_OFS 8'h24
`define I2CI_MASK_OFS  8'h2C
`define I2CI_RAW_OFS   8'h30
`define I2CI_STAT_OFS  8'h34
`define I2CI_CLR_OFS   8'h38

// ==========================================
// field positions
`define I2CI_B_TXE  0
`define I2CI_B_TXNE 1
`define I2CI_B_TXF  2
`define I2CI_B_TXOV 3
`define I2CI_B_RXE  4
`define I2CI_B_RXNF 5
`define I2CI_B_RXF  6
`define I2CI_B_SRR  16
`define I2CI_B_SRE  17
`define I2CI_B_SWR  18
`define I2CI_B_MD   19
`define I2CI_B_SD   20
`define I2CI_B_AL   24
`define I2CI_B_BE   25
`define I2CI_B_MDNS 28

// ==========================================
// masks and reset values
`define I2CI_VALID_M  32'h131F007F
`define I2CI_STICKY_M 32'h131F0008
`define I2CI_RST_W    32'h00000000
`define I2CI_THR_W    5
`define I2CI_CNT_W    5
`define I2CI_DEPTH    5'h10
`define I2CI_THR_RST  5'h00

`endif

// ---- src/i2ci_pkg.sv ----
// types shared by the interrupt status block
package i2ci_pkg;
  typedef logic [31:0] i2ci_word_t;
  typedef logic [7:0]  i2ci_addr_t;
  typedef logic [3:0]  i2ci_strb_t;
  typedef logic [4:0]  i2ci_cnt_t;
  typedef enum logic [1:0] {
    I2CI_OKAY   = 2'b00,
    I2CI_SLVERR = 2'b10
  } i2ci_resp_t;
endpackage

// ---- tb/i2ci_bus_peer.sv ----
// two-wire bus peer that frames a start, eight data bits and a stop
`timescale 1ns/1ps

module i2ci_bus_peer (
  input  wire logic scl_line,
  output logic      scl_o,
  output logic      sda_o
);
  localparam int HALF = 200;

  // released lines rest at the pull-up level
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // clock stands still between frames; a stretched low clock is waited out
  task automatic frame(input logic [7:0] b);
    // step off the sampling edge so the pins never move with the clock
    #10;
    sda_o = 1'b0;
    #HALF scl_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      #50 sda_o = b[i];
      #(HALF - 50) scl_o = 1'b1;
      wait (scl_line);
      #HALF scl_o = 1'b0;
    end
    #50 sda_o = 1'b0;
    #(HALF - 50) scl_o = 1'b1;
    #HALF sda_o = 1'b1;
    #HALF;
  endtask
endmodule

// ---- tb/i2c_irq_status_and_clear_tb_top.sv ----
// self-checking bench for the interrupt status and clear registers
`timescale 1ns/1ps
`include "i2ci_map.svh"

module i2c_irq_status_and_clear_tb_top;
  import i2ci_pkg::*;
  logic       MCLK = 1'b0, NRST = 1'b0;
  i2ci_addr_t AWADDR = '0, ARADDR = '0;
  i2ci_word_t WDATA = '0, RDATA;
  logic       AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic       AWREADY, WREADY, BVALID, ARREADY, RVALID, SCL_OUT, SCL_OE, IRQ;
  i2ci_resp_t BRESP, RRESP;
  i2ci_cnt_t  TXC = '0, RXC = '0;
  logic [6:0] evt = '0;
  logic       RDACT = 0, XACT = 0, scl_o, sda_o;
  int         n_errors = 0, total_checks = 0, cyc = 0, txth = 0, rxth = 0;
  logic [31:0] seed = 32'hB2EEC72C;
  i2ci_word_t sticky_exp = '0, msk = '0;
  logic [33:0] rq[$];
  i2ci_resp_t  wq[$];
  int         bitpos[7] = '{3, 16, 18, 19, 20, 24, 28};

  always #25 MCLK = ~MCLK;

  i2ci_top i_dut (.MCLK(MCLK), .NRST(NRST),
    .S_AXI_AWADDR(AWADDR), .S_AXI_AWVALID(AWVALID), .S_AXI_AWREADY(AWREADY),
    .S_AXI_WDATA(WDATA), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(WVALID), .S_AXI_WREADY(WREADY),
    .S_AXI_BRESP(BRESP), .S_AXI_BVALID(BVALID), .S_AXI_BREADY(BREADY),
    .S_AXI_ARADDR(ARADDR), .S_AXI_ARVALID(ARVALID), .S_AXI_ARREADY(ARREADY),
    .S_AXI_RDATA(RDATA), .S_AXI_RRESP(RRESP), .S_AXI_RVALID(RVALID), .S_AXI_RREADY(RREADY),
    .TX_COUNT(TXC), .RX_COUNT(RXC), .TX_OVERRUN_EVT(evt[0]), .SLV_RD_REQ_EVT(evt[1]),
    .SLV_RD_ACTIVE(RDACT), .SLV_WR_REQ_EVT(evt[2]), .MST_DONE_EVT(evt[3]),
    .MST_DONE_NOSTOP_EVT(evt[6]), .SLV_DONE_EVT(evt[4]), .ARB_LOST_EVT(evt[5]),
    .XFER_ACTIVE(XACT), .SCL_IN(scl_o & ~SCL_OE), .SDA_IN(sda_o),
    .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .IRQ(IRQ));

  i2ci_bus_peer i_peer (.scl_line(scl_o & ~SCL_OE), .scl_o(scl_o), .sda_o(sda_o));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // level bits follow the counts; sticky bits come from the model
  function automatic i2ci_word_t raw();
    raw = sticky_exp;
    raw[`I2CI_B_TXE]  = (TXC == 5'h00);
    raw[`I2CI_B_TXNE] = (TXC <= txth);
    raw[`I2CI_B_TXF]  = (TXC == `I2CI_DEPTH);
    raw[`I2CI_B_RXE]  = (RXC == 5'h00);
    raw[`I2CI_B_RXNF] = (RXC >= rxth);
    raw[`I2CI_B_RXF]  = (RXC == `I2CI_DEPTH);
  endfunction

  task automatic chk(input i2ci_word_t seen, input i2ci_word_t exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%08h expected=%08h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  task automatic axw(input i2ci_addr_t a, input i2ci_word_t d, input i2ci_resp_t r);
    wq.push_back(r);
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    do @(posedge MCLK); while (!(AWREADY && WREADY));
    AWVALID <= 1'b0;
    WVALID  <= 1'b0;
    do @(posedge MCLK); while (!BVALID);
    BREADY  <= 1'b0;
    // one edge between calls, so ready is never lowered and raised in one step
    @(posedge MCLK);
  endtask

  task automatic axr(input i2ci_addr_t a, input i2ci_word_t d, input i2ci_resp_t r);
    rq.push_back({r, d});
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    do @(posedge MCLK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge MCLK); while (!RVALID);
    RREADY  <= 1'b0;
    @(posedge MCLK);
  endtask

  // masked view, interrupt line and clock stretch against the model
  task automatic chk_stat();
    axr(`I2CI_STAT_OFS, raw() & msk, I2CI_OKAY);
    chk({31'h0, IRQ}, {31'h0, |(raw() & msk)});
    chk({31'h0, SCL_OE}, {31'h0, sticky_exp[`I2CI_B_MDNS]});
    chk({31'h0, SCL_OUT}, 32'h0);
  endtask

  // ==========================================
  // monitor: oldest note against each answer
  always @(posedge MCLK) begin
    if (RVALID && RREADY) begin
      logic [33:0] e;
      e = rq.pop_front();
      chk(RDATA, e[31:0]);
      chk({30'h0, RRESP}, {30'h0, e[33:32]});
    end
    if (BVALID && BREADY) begin
      i2ci_resp_t r;
      r = wq.pop_front();
      chk({30'h0, BRESP}, {30'h0, r});
    end
  end

  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end

  // ==========================================
  initial begin
    int t;
    tick(5);
    NRST <= 1'b1;
    tick(1);
    axr(`I2CI_STAT_OFS, `I2CI_RST_W, I2CI_OKAY);
    axr(`I2CI_CLR_OFS, `I2CI_RST_W, I2CI_OKAY);
    axr(`I2CI_TXTHR_OFS, 32'h0, I2CI_OKAY);
    axr(8'h3C, 32'h0, I2CI_SLVERR);
    axw(8'h3C, 32'h1, I2CI_SLVERR);
    $display("test reset done");

    // raw flags show through the mask only; randomised counts and thresholds
    msk = `I2CI_VALID_M;
    for (int i = 0; i < 16; i++) begin
      if (i == 12)
        msk = 32'h0000_0055;
      axw(`I2CI_MASK_OFS, msk, I2CI_OKAY);
      if (i % 4 == 0) begin
        txth = rnd() % 17;
        rxth = rnd() % 17;
        axw(`I2CI_TXTHR_OFS, txth, I2CI_OKAY);
        axw(`I2CI_RXTHR_OFS, rxth, I2CI_OKAY);
      end
      t = (i < 2) ? 0 : (i < 4) ? 16 : rnd() % 17;
      TXC <= t[4:0];
      t = (i < 2) ? 16 : (i < 4) ? 0 : rnd() % 17;
      RXC <= t[4:0];
      tick(2);
      chk_stat();
      axr(`I2CI_RAW_OFS, raw(), I2CI_OKAY);
    end
    msk = `I2CI_VALID_M;
    axw(`I2CI_MASK_OFS, msk, I2CI_OKAY);
    TXC <= 5'h03;
    $display("test levels done");

    // each event: set, survives a zero write, cleared by a one write
    for (int k = 0; k < 7; k++) begin
      evt[k] <= 1'b1;
      tick(1);
      evt[k] <= 1'b0;
      tick(1);
      sticky_exp[bitpos[k]] = 1'b1;
      chk_stat();
      axw(`I2CI_CLR_OFS, ~(32'h1 << bitpos[k]), I2CI_OKAY);
      chk_stat();
      axw(`I2CI_CLR_OFS, 32'h1 << bitpos[k], I2CI_OKAY);
      sticky_exp[bitpos[k]] = 1'b0;
      chk_stat();
    end
    $display("test events done");

    // slave requests held back while the no-stop completion is pending
    evt[6] <= 1'b1;
    tick(1);
    evt[6] <= 1'b0;
    evt[2:1] <= 2'b11;
    tick(1);
    evt[2:1] <= 2'b00;
    tick(1);
    sticky_exp[`I2CI_B_MDNS] = 1'b1;
    chk_stat();
    axw(`I2CI_CLR_OFS, 32'h1 << `I2CI_B_MDNS, I2CI_OKAY);
    tick(1);
    sticky_exp[`I2CI_B_MDNS] = 1'b0;
    sticky_exp[`I2CI_B_SRR]  = 1'b1;
    sticky_exp[`I2CI_B_SWR]  = 1'b1;
    chk_stat();
    axw(`I2CI_CLR_OFS, (32'h1 << `I2CI_B_SRR) | (32'h1 << `I2CI_B_SWR), I2CI_OKAY);
    sticky_exp[`I2CI_B_SRR] = 1'b0;
    sticky_exp[`I2CI_B_SWR] = 1'b0;
    chk_stat();
    $display("test deferral done");

    // transmit queue running dry during a slave read
    RDACT <= 1'b1;
    tick(1);
    TXC <= 5'h00;
    tick(2);
    sticky_exp[`I2CI_B_SRE] = 1'b1;
    chk_stat();
    TXC <= 5'h02;
    tick(2);
    sticky_exp[`I2CI_B_SRE] = 1'b0;
    chk_stat();
    TXC <= 5'h00;
    tick(2);
    sticky_exp[`I2CI_B_SRE] = 1'b1;
    chk_stat();
    axw(`I2CI_CLR_OFS, 32'h1 << `I2CI_B_SRE, I2CI_OKAY);
    sticky_exp[`I2CI_B_SRE] = 1'b0;
    chk_stat();
    RDACT <= 1'b0;
    $display("test slave read empty done");

    // start and stop outside a transaction are legal, inside are errors
    i_peer.frame(8'hA5);
    tick(8);
    chk_stat();
    @(posedge MCLK);
    XACT <= 1'b1;
    i_peer.frame(8'h3C);
    tick(8);
    XACT <= 1'b0;
    sticky_exp[`I2CI_B_BE] = 1'b1;
    chk_stat();
    axw(`I2CI_CLR_OFS, 32'h1 << `I2CI_B_BE, I2CI_OKAY);
    sticky_exp[`I2CI_B_BE] = 1'b0;
    chk_stat();
    $display("test bus error done");
    tick(3);
    test_done();
  end
endmodule
